// file: hdl/lane_err_counter.sv
// Saturating lane error counter with threshold comparison.
`timescale 1ns/1ps
`default_nettype none
module lane_err_counter
  import lane_status_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               clear,
  input  wire logic               err_pulse,
  input  wire logic [COUNT_W-1:0] threshold,
  output logic                    reached
);

  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic               reached_r;
  logic               reached_nxt;

  // Count errors up to saturation; the flag tracks the count it goes with.
  always_comb begin
    count_nxt = count_r;
    if (clear) begin
      count_nxt = COUNT_RST;
    end else if (err_pulse && (count_r != COUNT_MAX)) begin
      count_nxt = count_r + 8'h01;
    end
    reached_nxt = (count_nxt >= threshold);
  end

  // The flag reads zero while reset holds, whatever the threshold.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r   <= COUNT_RST;
      reached_r <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      reached_r <= reached_nxt;
    end
  end

  assign reached = reached_r;

endmodule
`default_nettype wire

// file: hdl/lane_link_status_regs.sv
// Paged per-lane link status registers behind an AXI4-Lite slave.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lane_link_status_regs
  import lane_status_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [DATA_W-1:0]    wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [ADDR_W-1:0]    araddr,
  input  wire logic [2:0]           arprot,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [DATA_W-1:0]         rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic [NUM_LINKS-1:0] lane1_disparity_err_pulse,
  input  wire logic [NUM_LINKS-1:0] lane1_bad_code_err_pulse,
  input  wire logic [NUM_LINKS-1:0] lane1_unexpected_ctrl_char_pulse,
  input  wire logic [NUM_LINKS-1:0] lane2_disparity_err_pulse,
  input  wire logic [NUM_LINKS-1:0] lane2_bad_code_err_pulse,
  input  wire logic [NUM_LINKS-1:0] lane2_unexpected_ctrl_char_pulse,
  input  wire logic [NUM_LINKS-1:0] lane1_deskew_done,
  input  wire logic [NUM_LINKS-1:0] lane1_initial_sync_done,
  input  wire logic [NUM_LINKS-1:0] lane1_checksum_ok,
  input  wire logic [NUM_LINKS-1:0] lane1_frame_sync_done,
  input  wire logic [NUM_LINKS-1:0] lane1_codegroup_sync_done,
  input  wire logic [NUM_LINKS-1:0] lane2_deskew_done,
  input  wire logic [NUM_LINKS-1:0] lane2_initial_sync_done,
  input  wire logic [NUM_LINKS-1:0] lane2_checksum_ok,
  input  wire logic [NUM_LINKS-1:0] lane2_frame_sync_done,
  input  wire logic [NUM_LINKS-1:0] lane2_codegroup_sync_done,
  output logic                      irq
);

  // Maps a byte address onto a register select code.
  function automatic logic [2:0] decode_sel(input logic [ADDR_W-1:0] a);
    logic [13:0] idx;
    idx = a[ADDR_W-1:2];
    case (idx)
      IDX_LINK_PAGE:    decode_sel = SEL_PAGE;
      IDX_LANE1_STATUS: decode_sel = SEL_LANE1;
      IDX_LANE2_STATUS: decode_sel = SEL_LANE2;
      IDX_ERR_THRESH:   decode_sel = SEL_THRESH;
      IDX_IRQ_STATUS:   decode_sel = SEL_ISTAT;
      IDX_IRQ_MASK:     decode_sel = SEL_IMASK;
      IDX_CNT_CLEAR:    decode_sel = SEL_CLEAR;
      default:          decode_sel = SEL_NONE;
    endcase
  endfunction

  // Packs one lane's threshold flags and sync levels into a status byte.
  function automatic logic [7:0] make_status(input logic [2:0] errs,
                                             input logic [4:0] lvls);
    logic [7:0] s;
    s          = STATUS_RST;
    s[BIT_BDE] = errs[ERR_BDE];
    s[BIT_NIT] = errs[ERR_NIT];
    s[BIT_UEK] = errs[ERR_UEK];
    s[BIT_ILD] = lvls[LVL_ILD];
    s[BIT_ILS] = lvls[LVL_ILS];
    s[BIT_CKS] = lvls[LVL_CKS];
    s[BIT_FS]  = lvls[LVL_FS];
    s[BIT_CGS] = lvls[LVL_CGS];
    make_status = s;
  endfunction

  logic [NUM_SYNC-1:0]  lvl_raw;
  logic [NUM_SYNC-1:0]  lvl_sync;
  logic [NUM_CNT-1:0]   err_ev;
  logic [NUM_CNT-1:0]   reached;
  logic [7:0]           lane_stat [NUM_LINKS][NUM_LANES];
  logic [7:0]           lane1_link_status;
  logic [7:0]           lane2_link_status;
  logic [WATCH_W-1:0]   watch;
  logic [IRQ_W-1:0]     irq_ev;

  logic                 aw_have_r;
  logic                 aw_have_nxt;
  logic [ADDR_W-1:0]    awaddr_r;
  logic [ADDR_W-1:0]    awaddr_nxt;
  logic                 w_have_r;
  logic                 w_have_nxt;
  logic [DATA_W-1:0]    wdata_r;
  logic [DATA_W-1:0]    wdata_nxt;
  logic [3:0]           wstrb_r;
  logic [3:0]           wstrb_nxt;
  logic                 bvalid_r;
  logic                 bvalid_nxt;
  logic [1:0]           bresp_r;
  logic [1:0]           bresp_nxt;
  logic                 rvalid_r;
  logic                 rvalid_nxt;
  logic [1:0]           rresp_r;
  logic [1:0]           rresp_nxt;
  logic [DATA_W-1:0]    rdata_r;
  logic [DATA_W-1:0]    rdata_nxt;

  logic                 link_page_r;
  logic                 link_page_nxt;
  logic [COUNT_W-1:0]   thresh_r;
  logic [COUNT_W-1:0]   thresh_nxt;
  logic [IRQ_W-1:0]     irq_mask_r;
  logic [IRQ_W-1:0]     irq_mask_nxt;
  logic [IRQ_W-1:0]     irq_stat_r;
  logic [IRQ_W-1:0]     irq_stat_nxt;
  logic [WATCH_W-1:0]   watch_r;
  logic                 cnt_clear_r;
  logic                 cnt_clear_nxt;

  logic                 aw_take;
  logic                 w_take;
  logic                 ar_take;
  logic                 do_write;
  logic [ADDR_W-1:0]    wr_addr;
  logic [DATA_W-1:0]    wr_data;
  logic [3:0]           wr_strb;
  logic [2:0]           wr_sel;
  logic [2:0]           rd_sel;

  // Gather lane inputs per link into flat vectors.
  for (genvar l = 0; l < NUM_LINKS; l++) begin : g_link
    assign lvl_raw[l*10 +: 5] = {lane1_deskew_done[l],
                                 lane1_initial_sync_done[l],
                                 lane1_checksum_ok[l],
                                 lane1_frame_sync_done[l],
                                 lane1_codegroup_sync_done[l]};
    assign lvl_raw[l*10+5 +: 5] = {lane2_deskew_done[l],
                                   lane2_initial_sync_done[l],
                                   lane2_checksum_ok[l],
                                   lane2_frame_sync_done[l],
                                   lane2_codegroup_sync_done[l]};
    assign err_ev[l*6 +: 3]   = {lane1_disparity_err_pulse[l],
                                 lane1_bad_code_err_pulse[l],
                                 lane1_unexpected_ctrl_char_pulse[l]};
    assign err_ev[l*6+3 +: 3] = {lane2_disparity_err_pulse[l],
                                 lane2_bad_code_err_pulse[l],
                                 lane2_unexpected_ctrl_char_pulse[l]};
    for (genvar n = 0; n < NUM_LANES; n++) begin : g_lane
      assign lane_stat[l][n] = make_status(reached[l*6+n*3 +: 3],
                                           lvl_sync[l*10+n*5 +: 5]);
    end
  end

  // Sync levels come from the serial lane domain.
  sync2 #(
    .WIDTH (NUM_SYNC)
  ) u_lvl_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (lvl_raw),
    .dout    (lvl_sync)
  );

  // One saturating counter per link, lane and error kind.
  for (genvar c = 0; c < NUM_CNT; c++) begin : g_cnt
    lane_err_counter u_cnt (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .clear     (cnt_clear_r),
      .err_pulse (err_ev[c]),
      .threshold (thresh_r),
      .reached   (reached[c])
    );
  end

  // The link page chooses which link both lane registers show.
  assign lane1_link_status = lane_stat[link_page_r][0];
  assign lane2_link_status = lane_stat[link_page_r][1];

  // Watched levels: threshold reached per lane, and sync absent per link and lane.
  assign watch = {~lvl_sync[15+LVL_CGS], ~lvl_sync[5+LVL_CGS],
                  ~lvl_sync[10+LVL_CGS], ~lvl_sync[LVL_CGS],
                  (|reached[9 +: 3]) | (|reached[3 +: 3]),
                  (|reached[6 +: 3]) | (|reached[0 +: 3])};

  // Rising edges of the watched levels become interrupt events.
  always_comb begin
    irq_ev                 = IRQ_RST;
    irq_ev[IRQ_LANE1_ERR]  = watch[0] & ~watch_r[0];
    irq_ev[IRQ_LANE2_ERR]  = watch[1] & ~watch_r[1];
    irq_ev[IRQ_LANE1_LOST] = (watch[2] & ~watch_r[2]) |
                             (watch[3] & ~watch_r[3]);
    irq_ev[IRQ_LANE2_LOST] = (watch[4] & ~watch_r[4]) |
                             (watch[5] & ~watch_r[5]);
  end

  // Handshake terms of the bus slave.
  assign awready  = !aw_have_r && !bvalid_r;
  assign wready   = !w_have_r && !bvalid_r;
  assign arready  = !rvalid_r;
  assign aw_take  = awvalid && awready;
  assign w_take   = wvalid && wready;
  assign ar_take  = arvalid && arready;
  assign wr_addr  = aw_have_r ? awaddr_r : awaddr;
  assign wr_data  = w_have_r ? wdata_r : wdata;
  assign wr_strb  = w_have_r ? wstrb_r : wstrb;
  assign do_write = (aw_have_r || aw_take) && (w_have_r || w_take);
  assign wr_sel   = decode_sel(wr_addr);
  assign rd_sel   = decode_sel(araddr);

  // Bus channel state: capture address and data in either order.
  always_comb begin
    aw_have_nxt = aw_have_r;
    awaddr_nxt  = awaddr_r;
    w_have_nxt  = w_have_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r && !bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r && !rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (aw_take) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt  = awaddr;
    end
    if (w_take) begin
      w_have_nxt = 1'b1;
      wdata_nxt  = wdata;
      wstrb_nxt  = wstrb;
    end
    if (do_write) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end
    if (ar_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      case (rd_sel)
        SEL_PAGE:   rdata_nxt = {{(DATA_W-1){1'b0}}, link_page_r};
        SEL_LANE1:  rdata_nxt = {{(DATA_W-8){1'b0}}, lane1_link_status};
        SEL_LANE2:  rdata_nxt = {{(DATA_W-8){1'b0}}, lane2_link_status};
        SEL_THRESH: rdata_nxt = {{(DATA_W-COUNT_W){1'b0}}, thresh_r};
        SEL_ISTAT:  rdata_nxt = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_r};
        SEL_IMASK:  rdata_nxt = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_r};
        default:    rdata_nxt = DATA_RST;
      endcase
    end
  end

  // Control registers; lane status selects take no write effect.
  always_comb begin
    link_page_nxt = link_page_r;
    thresh_nxt    = thresh_r;
    irq_mask_nxt  = irq_mask_r;
    cnt_clear_nxt = 1'b0;
    if (do_write && wr_strb[0]) begin
      case (wr_sel)
        SEL_PAGE:   link_page_nxt = wr_data[0];
        SEL_THRESH: thresh_nxt    = wr_data[COUNT_W-1:0];
        SEL_IMASK:  irq_mask_nxt  = wr_data[IRQ_W-1:0];
        SEL_CLEAR:  cnt_clear_nxt = wr_data[0];
        default:    link_page_nxt = link_page_r;
      endcase
    end
    // A read of the interrupt status register clears it, but an event in that same cycle still lands.
    irq_stat_nxt = ((ar_take && (rd_sel == SEL_ISTAT)) ? IRQ_RST
                                                       : irq_stat_r) | irq_ev;
  end

  // Register everything on each clock edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r   <= 1'b0;
      awaddr_r    <= '0;
      w_have_r    <= 1'b0;
      wdata_r     <= DATA_RST;
      wstrb_r     <= 4'h0;
      bvalid_r    <= 1'b0;
      bresp_r     <= RESP_OKAY;
      rvalid_r    <= 1'b0;
      rresp_r     <= RESP_OKAY;
      rdata_r     <= DATA_RST;
      link_page_r <= 1'b0;
      thresh_r    <= THRESH_RST;
      irq_mask_r  <= IRQ_RST;
      irq_stat_r  <= IRQ_RST;
      watch_r     <= WATCH_RST;
      cnt_clear_r <= 1'b0;
    end else begin
      aw_have_r   <= aw_have_nxt;
      awaddr_r    <= awaddr_nxt;
      w_have_r    <= w_have_nxt;
      wdata_r     <= wdata_nxt;
      wstrb_r     <= wstrb_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      rvalid_r    <= rvalid_nxt;
      rresp_r     <= rresp_nxt;
      rdata_r     <= rdata_nxt;
      link_page_r <= link_page_nxt;
      thresh_r    <= thresh_nxt;
      irq_mask_r  <= irq_mask_nxt;
      irq_stat_r  <= irq_stat_nxt;
      watch_r     <= watch;
      cnt_clear_r <= cnt_clear_nxt;
    end
  end

  // Outputs.
  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp  = rresp_r;
  assign rdata  = rdata_r;
  assign irq    = |(irq_stat_r & irq_mask_r);

endmodule
`default_nettype wire

// file: hdl/lane_status_pkg.sv
// Constants shared by the lane link status register bank.
package lane_status_pkg;

  // Bus and structure sizes.
  localparam int ADDR_W       = 16;
  localparam int DATA_W       = 32;
  localparam int NUM_LINKS    = 2;
  localparam int NUM_LANES    = 2;
  localparam int NUM_ERR      = 3;
  localparam int NUM_LVL      = 5;
  localparam int COUNT_W      = 8;
  localparam int IRQ_W        = 4;
  localparam int WATCH_W      = 6;
  localparam int NUM_CNT      = NUM_LINKS * NUM_LANES * NUM_ERR;
  localparam int NUM_SYNC     = NUM_LINKS * NUM_LANES * NUM_LVL;

  // Register indices; the byte address is four times the index.
  localparam logic [13:0] IDX_LINK_PAGE    = 14'h0300;
  localparam logic [13:0] IDX_LANE1_STATUS = 14'h04B1;
  localparam logic [13:0] IDX_LANE2_STATUS = 14'h04B2;
  localparam logic [13:0] IDX_ERR_THRESH   = 14'h0310;
  localparam logic [13:0] IDX_IRQ_STATUS   = 14'h0311;
  localparam logic [13:0] IDX_IRQ_MASK     = 14'h0312;
  localparam logic [13:0] IDX_CNT_CLEAR    = 14'h0313;

  // Register select codes produced by the address decoder.
  localparam logic [2:0] SEL_NONE   = 3'h0;
  localparam logic [2:0] SEL_PAGE   = 3'h1;
  localparam logic [2:0] SEL_LANE1  = 3'h2;
  localparam logic [2:0] SEL_LANE2  = 3'h3;
  localparam logic [2:0] SEL_THRESH = 3'h4;
  localparam logic [2:0] SEL_ISTAT  = 3'h5;
  localparam logic [2:0] SEL_IMASK  = 3'h6;
  localparam logic [2:0] SEL_CLEAR  = 3'h7;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Bit positions inside a lane status byte.
  localparam int BIT_BDE = 7;
  localparam int BIT_NIT = 6;
  localparam int BIT_UEK = 5;
  localparam int BIT_ILD = 4;
  localparam int BIT_ILS = 3;
  localparam int BIT_CKS = 2;
  localparam int BIT_FS  = 1;
  localparam int BIT_CGS = 0;

  // Positions inside the per-lane error and level groups.
  localparam int ERR_BDE = 2;
  localparam int ERR_NIT = 1;
  localparam int ERR_UEK = 0;
  localparam int LVL_ILD = 4;
  localparam int LVL_ILS = 3;
  localparam int LVL_CKS = 2;
  localparam int LVL_FS  = 1;
  localparam int LVL_CGS = 0;

  // Interrupt status bit positions.
  localparam int IRQ_LANE1_ERR  = 0;
  localparam int IRQ_LANE2_ERR  = 1;
  localparam int IRQ_LANE1_LOST = 2;
  localparam int IRQ_LANE2_LOST = 3;

  // Reset values and the counter saturation limit.
  localparam logic [7:0]         STATUS_RST = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RST  = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_MAX  = 8'hFF;
  localparam logic [COUNT_W-1:0] THRESH_RST = 8'hFF;
  localparam logic [IRQ_W-1:0]   IRQ_RST    = 4'h0;
  localparam logic [WATCH_W-1:0] WATCH_RST  = 6'h3C;
  localparam logic [DATA_W-1:0]  DATA_RST   = 32'h0000_0000;

endpackage

// file: hdl/sync2.sv
// Two-flip-flop synchroniser for level signals from the lane domain.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_nxt = din;
    sync_nxt = meta_r;
  end

  // Both stages clear to zero under reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign dout = sync_r;

endmodule
`default_nettype wire

// file: test/lane_link_status_regs_bench.sv
// Self-checking bench for the lane link status register bank.
`timescale 1ns/1ps
`default_nettype none
module lane_link_status_regs_bench;
  import lane_status_pkg::*;
  localparam logic [15:0] A_PAGE = {IDX_LINK_PAGE, 2'b00};
  localparam logic [15:0] A_L1   = {IDX_LANE1_STATUS, 2'b00};
  localparam logic [15:0] A_L2   = {IDX_LANE2_STATUS, 2'b00};
  localparam logic [15:0] A_THR  = {IDX_ERR_THRESH, 2'b00};
  localparam logic [15:0] A_IST  = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [15:0] A_MSK  = {IDX_IRQ_MASK, 2'b00};
  localparam logic [15:0] A_CLR  = {IDX_CNT_CLEAR, 2'b00};
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rd_d;
  logic [3:0]  wstrb;
  logic [2:0]  awprot, arprot;
  logic [1:0]  rd_r;
  wire logic awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [1:0] lane1_disparity_err_pulse, lane1_bad_code_err_pulse,
    lane1_unexpected_ctrl_char_pulse, lane2_disparity_err_pulse,
    lane2_bad_code_err_pulse, lane2_unexpected_ctrl_char_pulse,
    lane1_deskew_done, lane1_initial_sync_done, lane1_checksum_ok,
    lane1_frame_sync_done, lane1_codegroup_sync_done, lane2_deskew_done,
    lane2_initial_sync_done, lane2_checksum_ok, lane2_frame_sync_done,
    lane2_codegroup_sync_done;
  logic [11:0] err_req, err;
  logic [19:0] lvl_req, lvl;
  logic [7:0]  thr;
  int cnt [2][2][3];
  int bad_count;
  int checks;
  // Route the model's packed vectors onto the named lane pins.
  assign {lane2_disparity_err_pulse, lane2_bad_code_err_pulse,
    lane2_unexpected_ctrl_char_pulse, lane1_disparity_err_pulse,
    lane1_bad_code_err_pulse, lane1_unexpected_ctrl_char_pulse} = err;
  assign {lane2_deskew_done, lane2_initial_sync_done, lane2_checksum_ok,
    lane2_frame_sync_done, lane2_codegroup_sync_done, lane1_deskew_done,
    lane1_initial_sync_done, lane1_checksum_ok, lane1_frame_sync_done,
    lane1_codegroup_sync_done} = lvl;
  lane_link_status_regs DUT (.*);
  lane_tx_model tx (.aclk(aclk), .err_req(err_req), .lvl_req(lvl_req),
    .err(err), .lvl(lvl));
  // The clock toggles every half period of 5 ns.
  always #5 aclk = ~aclk;
  task automatic close_out;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic give_up;
    bad_count++;
    $display("FAIL bus answer expected 1 seen 0");
    close_out();
  endtask
  // Write cycle; handshakes are judged on the settled values before the edge.
  // A randomly low bready stalls the response for one cycle.
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ah, wh, bh, bv;
    logic [1:0] r;
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom);
    for (n = 0; n < 64; n++) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      bv = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bv && !bh) bready <= 1'b1;
      if (bh) break;
    end
    if (n == 64) give_up();
    check("bresp", {30'h0, er}, {30'h0, r});
  endtask
  // Read cycle; the answer is taken in the cycle where rvalid and rready are both seen.
  task automatic rd_raw(input logic [15:0] a);
    logic ah, rh, rv;
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom);
    for (n = 0; n < 64; n++) begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid && rready;
      rv = rvalid;
      rd_d = rdata;
      rd_r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rv && !rh) rready <= 1'b1;
      if (rh) break;
    end
    if (n == 64) give_up();
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    rd_raw(a);
    check("rdata", ed, rd_d);
    check("rresp", {30'h0, er}, {30'h0, rd_r});
  endtask
  // Expected status byte of one lane on one link.
  function automatic logic [31:0] exp_st(input int lk, input int ln);
    logic [31:0] s;
    s = 32'h0000_0000;
    for (int v = 0; v < 5; v++) s[v] = lvl_req[(ln*5+v)*2+lk];
    for (int k = 0; k < 3; k++) s[5+k] = cnt[lk][ln][k] >= int'(thr);
    return s;
  endfunction
  // Sends error pulses, either a fixed mask or sparse random ones.
  task automatic pulses(input int n, input logic [11:0] m);
    logic [11:0] e;
    for (int i = 0; i < n; i++) begin
      e = (m != 12'h000) ? m : 12'($urandom & $urandom & $urandom);
      err_req <= e;
      for (int b = 0; b < 12; b++)
        if (e[b] && cnt[b%2][b/6][(b/2)%3] < 255) cnt[b%2][b/6][(b/2)%3]++;
      @(posedge aclk);
    end
    err_req <= 12'h000;
    repeat (5) @(posedge aclk);
  endtask
  task automatic clear_counts;
    wr(A_CLR, 32'h0000_0001, RESP_OKAY);
    cnt = '{default: 0};
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = 64'h0;
    wstrb = 4'hF;
    {awprot, arprot} = 6'h00;
    {err_req, lvl_req} = 32'h0;
    thr = THRESH_RST;
    cnt = '{default: 0};
    bad_count = 0;
    checks = 0;
    void'($urandom(28));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_L1, 32'h0000_0000, RESP_OKAY);
    rd(A_L2, 32'h0000_0000, RESP_OKAY);
    rd(A_THR, 32'h0000_00FF, RESP_OKAY);
    rd(16'h0004, 32'h0000_0000, RESP_DECERR);
    wr(16'h0008, 32'h0000_0001, RESP_DECERR);
    for (int it = 0; it < 10; it++) begin
      lvl_req <= 20'($urandom);
      thr = (it == 0) ? 8'h00 : 8'($urandom_range(40));
      if (it == 5) clear_counts();
      wr(A_THR, {24'h0, thr}, RESP_OKAY);
      pulses(20, 12'h000);
      for (int lk = 0; lk < 2; lk++) begin
        wr(A_PAGE, 32'(lk), RESP_OKAY);
        rd(A_L1, exp_st(lk, 0), RESP_OKAY);
        rd(A_L2, exp_st(lk, 1), RESP_OKAY);
        wr(A_L2, 32'h0000_00FF, RESP_OKAY);
        rd(A_L2, exp_st(lk, 1), RESP_OKAY);
      end
    end
    lvl_req <= 20'hF_FFFF;
    thr = 8'h03;
    wr(A_THR, 32'h0000_0003, RESP_OKAY);
    wr(A_MSK, 32'h0000_0000, RESP_OKAY);
    wr(A_PAGE, 32'h0000_0000, RESP_OKAY);
    clear_counts();
    rd_raw(A_IST);
    pulses(2, 12'h001);
    rd(A_L1, exp_st(0, 0), RESP_OKAY);
    pulses(1, 12'h001);
    rd(A_L1, exp_st(0, 0), RESP_OKAY);
    check("irq", 32'h0, {31'h0, irq});
    wr(A_MSK, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq", 32'h1, {31'h0, irq});
    rd(A_IST, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq", 32'h0, {31'h0, irq});
    lvl_req[11] <= 1'b0;
    repeat (6) @(posedge aclk);
    check("irq", 32'h0, {31'h0, irq});
    wr(A_MSK, 32'h0000_0008, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq", 32'h1, {31'h0, irq});
    rd(A_IST, 32'h0000_0008, RESP_OKAY);
    wstrb <= 4'hE;
    wr(A_MSK, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hF;
    rd(A_MSK, 32'h0000_0008, RESP_OKAY);
    close_out();
  end
endmodule
bind lane_link_status_regs lane_link_status_regs_chk chk (.*);
`default_nettype wire

// file: test/lane_link_status_regs_chk.sv
// Checker for bus timing and status bits of the lane status bank.
`timescale 1ns/1ps
`default_nettype none
module lane_link_status_regs_chk
  import lane_status_pkg::*;
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic [ADDR_W-1:0]    awaddr,
  input wire logic                 awvalid,
  input wire logic                 awready,
  input wire logic [1:0]           bresp,
  input wire logic                 bvalid,
  input wire logic                 bready,
  input wire logic [ADDR_W-1:0]    araddr,
  input wire logic                 arvalid,
  input wire logic                 arready,
  input wire logic [DATA_W-1:0]    rdata,
  input wire logic [1:0]           rresp,
  input wire logic                 rvalid,
  input wire logic                 rready,
  input wire logic [NUM_LINKS-1:0] lane1_frame_sync_done,
  input wire logic [NUM_LINKS-1:0] lane2_codegroup_sync_done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0] rd_sel_r;
  logic       wr_lane_r;
  logic [3:0] hi2_r;
  logic [3:0] lo1_r;
  // Tracks what the last request addressed and how long levels have held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_sel_r <= 2'h0;
      wr_lane_r <= 1'b0;
      hi2_r <= 4'h0;
      lo1_r <= 4'h0;
    end else begin
      if (arvalid && arready)
        rd_sel_r <= (araddr[15:2] == IDX_LANE1_STATUS) ? 2'h1 :
                    (araddr[15:2] == IDX_LANE2_STATUS) ? 2'h2 : 2'h0;
      if (awvalid && awready)
        wr_lane_r <= (awaddr[15:2] == IDX_LANE1_STATUS) ||
                     (awaddr[15:2] == IDX_LANE2_STATUS);
      hi2_r <= (&lane2_codegroup_sync_done) ?
               hi2_r + {3'h0, hi2_r != 4'hF} : 4'h0;
      lo1_r <= (lane1_frame_sync_done == 2'h0) ?
               lo1_r + {3'h0, lo1_r != 4'hF} : 4'h0;
    end
  end
  AST_RD_NEXT:
    assert property (arvalid && arready |=> rvalid)
    else $error("read answer not one cycle after address");
  AST_RD_HOLD:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before ready");
  AST_WR_HOLD:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before ready");
  AST_AR_BLOCK:
    assert property (rvalid |-> !arready)
    else $error("read address accepted while answer pending");
  AST_LANE_RD_OK:
    assert property (rvalid && rd_sel_r != 2'h0 |->
                     rresp == RESP_OKAY && rdata[31:8] == 24'h00_0000)
    else $error("lane status read answered wrongly");
  AST_STATUS_WR_OK:
    assert property ($rose(bvalid) && wr_lane_r |-> bresp == RESP_OKAY)
    else $error("write to lane status not answered okay");
  AST_LANE2_CODEGROUP_SYNC_DONE_HIGH:
    assert property ($rose(rvalid) && rd_sel_r == 2'h2 && hi2_r >= 4'h6
                     |-> rdata[0])
    else $error("lane 2 code group sync bit not set");
  AST_FS1_LOW:
    assert property ($rose(rvalid) && rd_sel_r == 2'h1 && lo1_r >= 4'h6
                     |-> !rdata[1])
    else $error("lane 1 frame sync bit set while lost");
endmodule
`default_nettype wire

// file: test/lane_tx_model.sv
// Behavioural lane transmitter: error pulses and sync levels per link.
`timescale 1ns/1ps
`default_nettype none
module lane_tx_model (
  input  wire logic        aclk,
  input  wire logic [11:0] err_req,
  input  wire logic [19:0] lvl_req,
  output logic      [11:0] err,
  output logic      [19:0] lvl
);
  // Each requested error leaves as one pulse; levels follow the request.
  always_ff @(posedge aclk) begin
    err <= err_req;
    lvl <= lvl_req;
  end
endmodule
`default_nettype wire
